// ### hw/dacrc_top.sv
/*
  converter register control: three sfr registers, word assembly and the
  controls to the analog converter section.
  assumes the core drives write and read strobes synchronous to mclk_i.
*/
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: in 12-bit mode the converter word updates only when the low byte is written
// RULE2: software should write the high byte first, then the low byte
// RULE3: 12-bit word is right-justified: low byte bits 7..0, high nibble bits 11..8
// RULE4: control bit 3 puts low byte on top eight bits, bottom four forced zero
// RULE5: control bit 4 picks the output route, set is the alternate pin
// RULE6: control bit 2 picks range, set is supply, clear is internal reference
// RULE7: control bit 1 low holds both data registers at zero
// RULE8: control bit 0 low asserts power-down to the analog section
// RULE9: control bits 7..5 are reserved, have no function and read as zero
// RULE10: upper high nibble ignored; 8-bit mode updates on each low byte write
module dacrc_top (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [dacrc_pkg::DACRC_ADDR_W-1:0] sfr_addr_i,
  input wire logic [dacrc_pkg::DACRC_DATA_W-1:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [dacrc_pkg::DACRC_DATA_W-1:0] sfr_rdata_o,
  output logic sfr_sel_o,
  output dacrc_pkg::dacrc_analog_t analog_o
);
  import dacrc_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the word assembly below is written for an 8-bit sfr bus and a 12-bit word
  if (DACRC_ADDR_W != 8) begin : g_chk_addr_w
    $error("dacrc_top: sfr address width must be 8");
  end
  if (DACRC_DATA_W != 8) begin : g_chk_data_w
    $error("dacrc_top: sfr data width must be 8");
  end
  if (DACRC_CONV_W != 12) begin : g_chk_conv_w
    $error("dacrc_top: converter word width must be 12");
  end
  if ((DACRC_ADDR_DATA_LOW == DACRC_ADDR_DATA_HIGH) ||
      (DACRC_ADDR_DATA_LOW == DACRC_ADDR_CONTROL) ||
      (DACRC_ADDR_DATA_HIGH == DACRC_ADDR_CONTROL)) begin : g_chk_addr
    $error("dacrc_top: register addresses must differ");
  end
  if (DACRC_CONTROL_MASK[7:5] != 3'h0) begin : g_chk_mask
    $error("dacrc_top: reserved control bits must stay masked");
  end
  if (!DACRC_CONTROL_MASK[DACRC_BIT_POWER_EN] || !DACRC_CONTROL_MASK[DACRC_BIT_CLEAR_N] ||
      !DACRC_CONTROL_MASK[DACRC_BIT_RANGE] || !DACRC_CONTROL_MASK[DACRC_BIT_BYTE_MODE] ||
      !DACRC_CONTROL_MASK[DACRC_BIT_ROUTE]) begin : g_chk_bits
    $error("dacrc_top: control bit positions must lie inside the kept field");
  end

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0] conv_data_low_q, conv_data_low_d;
  logic [7:0] conv_data_high_q, conv_data_high_d;
  logic [7:0] converter_control_q, converter_control_d;
  logic [11:0] conv_word_q, conv_word_d;
  logic [7:0] rdata_q, rdata_d;
  logic sel_q, sel_d;
  logic wr_low, wr_high, wr_ctrl;
  logic rd_low, rd_high, rd_ctrl;
  logic clear_n, byte_mode;

  // ************************************************************
  // address decode
  // ************************************************************
  // unmapped addresses leave every strobe low, so they neither write nor select
  always_comb begin
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_ctrl = 1'b0;
    rd_low = 1'b0;
    rd_high = 1'b0;
    rd_ctrl = 1'b0;
    if (sfr_addr_i == DACRC_ADDR_DATA_LOW) begin
      wr_low = sfr_wr_i;
      rd_low = sfr_rd_i;
    end else if (sfr_addr_i == DACRC_ADDR_DATA_HIGH) begin
      wr_high = sfr_wr_i;
      rd_high = sfr_rd_i;
    end else if (sfr_addr_i == DACRC_ADDR_CONTROL) begin
      wr_ctrl = sfr_wr_i;
      rd_ctrl = sfr_rd_i;
    end
  end

  // a control write that clears data takes effect on the same edge
  assign clear_n = wr_ctrl ? sfr_wdata_i[DACRC_BIT_CLEAR_N]
                           : converter_control_q[DACRC_BIT_CLEAR_N];
  assign byte_mode = converter_control_q[DACRC_BIT_BYTE_MODE];

  // ************************************************************
  // control register
  // ************************************************************
  // enable, range, route and mode act from the edge after the write
  always_comb begin
    converter_control_d = converter_control_q;
    if (wr_ctrl) begin
      // reserved bits are never stored, so they cannot steer anything
      converter_control_d = sfr_wdata_i & DACRC_CONTROL_MASK; // RULE9
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      converter_control_q <= DACRC_RST_CONTROL;
    end else begin
      converter_control_q <= converter_control_d;
    end
  end

  // ************************************************************
  // data registers
  // ************************************************************
  // after reset the clear bit is low, so data writes do nothing until it is set
  always_comb begin
    conv_data_low_d = conv_data_low_q;
    conv_data_high_d = conv_data_high_q;
    if (wr_low) begin
      conv_data_low_d = sfr_wdata_i;
    end
    if (wr_high) begin
      // the whole byte is kept for readback; only its low nibble reaches the word
      conv_data_high_d = sfr_wdata_i; // RULE10
    end
    // clear wins over any data write in the same cycle
    if (!clear_n) begin
      conv_data_low_d = DACRC_RST_DATA_LOW; // RULE7
      conv_data_high_d = DACRC_RST_DATA_HIGH; // RULE7
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_data_low_q <= DACRC_RST_DATA_LOW;
      conv_data_high_q <= DACRC_RST_DATA_HIGH;
    end else begin
      conv_data_low_q <= conv_data_low_d;
      conv_data_high_q <= conv_data_high_d;
    end
  end

  // ************************************************************
  // converter word
  // ************************************************************
  // a high byte write alone never reaches the converter, so software can stage
  // the top nibble without showing an intermediate value
  always_comb begin
    conv_word_d = conv_word_q;
    if (wr_low) begin
      if (byte_mode) begin
        conv_word_d = {sfr_wdata_i, 4'h0}; // RULE4 RULE10
      end else begin
        conv_word_d = {conv_data_high_q[3:0], sfr_wdata_i}; // RULE1 RULE3 RULE10
      end
    end
    // a mode change alone keeps the word; the next low byte write applies it
    if (!clear_n) begin
      conv_word_d = DACRC_RST_CONV; // RULE7
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_word_q <= DACRC_RST_CONV;
    end else begin
      conv_word_q <= conv_word_d;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // registered so the data comes from a flop; it stands for one cycle only,
  // and a read in the cycle of a write shows the value from before the write
  always_comb begin
    rdata_d = 8'h00;
    sel_d = 1'b0;
    if (rd_low) begin
      rdata_d = conv_data_low_q;
      sel_d = 1'b1;
    end else if (rd_high) begin
      rdata_d = conv_data_high_q;
      sel_d = 1'b1;
    end else if (rd_ctrl) begin
      rdata_d = converter_control_q; // RULE9
      sel_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
      sel_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      sel_q <= sel_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign sfr_rdata_o = rdata_q;
  assign sfr_sel_o = sel_q;
  assign analog_o.conv_word = conv_word_q;
  assign analog_o.output_route_select = converter_control_q[DACRC_BIT_ROUTE]; // RULE5
  assign analog_o.range_select = converter_control_q[DACRC_BIT_RANGE]; // RULE6
  // reset leaves the enable low, so the converter starts powered down
  assign analog_o.power_down = ~converter_control_q[DACRC_BIT_POWER_EN]; // RULE8
endmodule : dacrc_top

// ### hw/dacrc_pkg.sv
/*
  package for the converter register control block: sfr addresses, control bit
  positions, reset values and the packed carrier for the analog controls.
  assumes an 8-bit sfr address and data bus from the core.
*/
package dacrc_pkg;
  localparam int unsigned DACRC_ADDR_W = 8;
  localparam int unsigned DACRC_DATA_W = 8;
  localparam int unsigned DACRC_CONV_W = 12;
  localparam logic [7:0] DACRC_ADDR_DATA_LOW = 8'hfb;
  localparam logic [7:0] DACRC_ADDR_DATA_HIGH = 8'hfc;
  localparam logic [7:0] DACRC_ADDR_CONTROL = 8'hfd;
  localparam logic [7:0] DACRC_RST_DATA_LOW = 8'h00;
  localparam logic [7:0] DACRC_RST_DATA_HIGH = 8'h00;
  localparam logic [7:0] DACRC_RST_CONTROL = 8'h00;
  localparam logic [11:0] DACRC_RST_CONV = 12'h000;
  localparam int unsigned DACRC_BIT_POWER_EN = 0;
  localparam int unsigned DACRC_BIT_CLEAR_N = 1;
  localparam int unsigned DACRC_BIT_RANGE = 2;
  localparam int unsigned DACRC_BIT_BYTE_MODE = 3;
  localparam int unsigned DACRC_BIT_ROUTE = 4;
  localparam logic [7:0] DACRC_CONTROL_MASK = 8'h1f;

  typedef struct packed {
    logic output_route_select;
    logic range_select;
    logic power_down;
    logic [11:0] conv_word;
  } dacrc_analog_t;
endpackage : dacrc_pkg

// ### sim/dacrc_props.sv
/* checker for dacrc_top, bound below; assumes dacrc_pkg compiled first */
`timescale 1ns/10ps
module dacrc_props import dacrc_pkg::*; (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_sel_o,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input dacrc_analog_t analog_o);
  logic [7:0] c_q, h_q;
  wire [11:0] cw = analog_o.conv_word;
  wire wl = sfr_wr_i && sfr_addr_i == 8'hfb;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // shadow of the control register, so the checks do not trust a readback
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i) c_q <= 8'h00; else if (sfr_wr_i && sfr_addr_i == 8'hfd) c_q <= sfr_wdata_i;
  // shadow of the high byte; it only moves while the clear bit is high
  always_ff @(posedge mclk_i or negedge resetn_i)
    if (!resetn_i) h_q <= 8'h00;
    else if (sfr_wr_i && sfr_addr_i == 8'hfd && !sfr_wdata_i[1]) h_q <= 8'h00;
    else if (sfr_wr_i && sfr_addr_i == 8'hfc && c_q[1]) h_q <= sfr_wdata_i;
  AST_HI: assert property (sfr_wr_i && sfr_addr_i == 8'hfc |=> $stable(cw))
    else $error("high write moved word");
  AST_LO: assert property (wl && c_q[1] && !c_q[3] |=> cw[7:0] == $past(sfr_wdata_i))
    else $error("low byte wrong");
  AST_B8: assert property (wl && c_q[1] && c_q[3] |=> cw == {$past(sfr_wdata_i), 4'h0})
    else $error("byte mode word wrong");
  AST_RT: assert property (analog_o.output_route_select == c_q[4]) else $error("route");
  AST_RN: assert property (analog_o.range_select == c_q[2]) else $error("range");
  AST_CL: assert property (!c_q[1] |-> cw == 12'h000) else $error("clear");
  AST_PD: assert property (analog_o.power_down != c_q[0]) else $error("power");
  AST_RS: assert property (sfr_rd_i && sfr_addr_i == 8'hfd |=> sfr_rdata_o[7:5] == 3'h0)
    else $error("spare bits set");
  AST_HN: assert property (wl && c_q[1] && !c_q[3] |=> cw[11:8] == $past(h_q[3:0]))
    else $error("top nibble not from high byte");
  AST_RB: assert property (sfr_rd_i && sfr_addr_i == 8'hfd |=> sfr_sel_o &&
    sfr_rdata_o == {3'h0, $past(c_q[4:0])}) else $error("control readback wrong");
endmodule : dacrc_props
bind dacrc_top dacrc_props chk (.mclk_i, .resetn_i, .sfr_wr_i, .sfr_rd_i, .sfr_sel_o,
  .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .analog_o);

// ### sim/dacrc_core_model.sv
/* core-side sfr master model; assumes a free-running mclk_i */
`timescale 1ns/10ps
module dacrc_core_model (
  input wire logic mclk_i,
  output logic [7:0] addr_o,
  output logic [7:0] data_o,
  output logic wr_o,
  output logic rd_o);
  initial {addr_o, data_o, wr_o, rd_o} = 18'h0;
  // one access per call; released bus shows the inverse, never stale values
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge mclk_i) {addr_o, data_o, wr_o, rd_o} <= {a, d, w, !w};
    @(posedge mclk_i) {addr_o, data_o, wr_o, rd_o} <= {~a, ~d, 2'b00};
  endtask : acc
endmodule : dacrc_core_model

// ### sim/dacrc_top_tb_top.sv
/* testbench for dacrc_top; the core model drives every sfr access */
`timescale 1ns/10ps
module dacrc_top_tb_top;
  import dacrc_pkg::*;
  logic mclk_i = 1'b0, resetn_i = 1'b0, wr, rd, sel;
  logic [7:0] a, d, rdata;
  dacrc_analog_t an;
  int err_total = 0, checks_done = 0;
  dacrc_core_model core (.mclk_i, .addr_o(a), .data_o(d), .wr_o(wr), .rd_o(rd));
  dacrc_top dut (.mclk_i, .resetn_i, .sfr_addr_i(a), .sfr_wdata_i(d), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_rdata_o(rdata), .sfr_sel_o(sel), .analog_o(an));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic t(input logic w, input logic [7:0] ad, dt, input logic [14:0] ea,
    input logic [8:0] er);
    core.acc(w, ad, dt);
    #1 checks_done++;
    if ({an, sel, rdata} !== {ea, er}) begin
      err_total++;
      $display("Error bus exp %h got %h", {ea, er}, {an, sel, rdata});
    end
  endtask : t
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t(1'b0, 8'hfd, 8'h00, 15'h1000, 9'h100);
    t(1'b1, 8'hfd, 8'hff, 15'h6000, 9'h000);
    t(1'b0, 8'hfd, 8'h00, 15'h6000, 9'h11f);
    $display("test control done");
    t(1'b1, 8'hfb, 8'ha5, 15'h6a50, 9'h000);
    t(1'b1, 8'hfd, 8'h03, 15'h0a50, 9'h000);
    t(1'b1, 8'hfc, 8'hfa, 15'h0a50, 9'h000);
    t(1'b1, 8'hfb, 8'hbc, 15'h0abc, 9'h000);
    t(1'b0, 8'hfb, 8'h00, 15'h0abc, 9'h1bc);
    t(1'b1, 8'hfd, 8'h01, 15'h0000, 9'h000);
    t(1'b0, 8'hfc, 8'h00, 15'h0000, 9'h100);
    t(1'b1, 8'hfd, 8'h00, 15'h1000, 9'h000);
    t(1'b1, 8'hfb, 8'h55, 15'h1000, 9'h000);
    t(1'b0, 8'hfb, 8'h00, 15'h1000, 9'h100);
    t(1'b0, 8'h10, 8'h00, 15'h1000, 9'h000); // unmapped place reads zero
    $display("test data done");
    complete_run();
  end
  // whole run is about 32 cycles; this span allows over sixty times that
  initial begin
    #20000 err_total++;
    complete_run();
  end
endmodule : dacrc_top_tb_top
